// File: dv/ric_ctrl_asserts.sv
`timescale 1ns/1ns
`include "ric_map.svh"

// ----------------------------------------
// Port checker for the reset and interrupt control
// ----------------------------------------
module ric_ctrl_asserts
#(
   parameter int PC_WIDTH = 12
)
(
   input logic sys_clk,
   input logic rst,
   input logic [`RIC_OPT_WIDTH-1:0] option_word,
   input logic watchdog_expired,
   input logic timer_overflow,
   input logic global_irq_on_op,
   input logic global_irq_off_op,
   input logic return_from_irq_op,
   input logic watchdog_clear_op,
   input logic enter_sleep_op,
   input logic [PC_WIDTH-1:0] return_pc,
   input logic core_reset,
   input logic timeout_flag,
   input logic powerdown_flag,
   input logic [1:0] interrupt_flag_register,
   input logic [1:0] interrupt_mask_register,
   input logic global_irq_enable,
   input logic vector_load,
   input logic [PC_WIDTH-1:0] vector_addr,
   input logic stack_push,
   input logic [PC_WIDTH-1:0] stack_push_data,
   input logic sleeping,
   input ric_pkg::ric_osc_mode_t osc_mode,
   input logic watchdog_enable
);
   // Every check samples on the system clock and rests while reset is high.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // A pending unmasked request with the global enable set vectors to the hardware slot.
   chk_hw_vector_taken: assert property (global_irq_enable && !sleeping
      && !core_reset && (|(interrupt_flag_register & interrupt_mask_register))
      |=> vector_load && vector_addr == `RIC_VEC_HW_IRQ) else $error("hardware vector not taken");
   chk_req_needs_mask: assert property (vector_load && vector_addr == `RIC_VEC_HW_IRQ
      |-> $past(|(interrupt_flag_register & interrupt_mask_register)))
      else $error("vector without masked flag");
   chk_push_with_vector: assert property (vector_load |-> stack_push
      && stack_push_data == $past(return_pc)) else $error("return address not pushed");
   chk_take_clears_en: assert property (vector_load |-> !global_irq_enable)
      else $error("enable kept after vector");
   chk_on_sets_en: assert property ((global_irq_on_op || return_from_irq_op)
      && !global_irq_off_op && !global_irq_enable && !core_reset |=> global_irq_enable)
      else $error("enable not set");
   chk_off_clears_en: assert property (global_irq_off_op && !global_irq_on_op
      && !return_from_irq_op |=> !global_irq_enable) else $error("enable not cleared");
   chk_timer_flag_set: assert property (timer_overflow && !core_reset
      |=> interrupt_flag_register[`RIC_IRQ_TIMER_BIT]) else $error("timer flag not set");
   chk_watchdog_clear_op_flags: assert property (watchdog_clear_op && !watchdog_expired && !core_reset
      |=> timeout_flag && powerdown_flag) else $error("watchdog clear flags wrong");
   chk_sleep_flags: assert property (enter_sleep_op && !sleeping && !watchdog_clear_op
      && !watchdog_expired && !core_reset |=> sleeping && timeout_flag && !powerdown_flag)
      else $error("sleep flags wrong");
   chk_wdog_timeout: assert property (watchdog_expired && watchdog_enable
      |=> !timeout_flag) else $error("watchdog time-out flag not cleared");
   chk_osc_rc_mode: assert property ($stable(option_word) && !option_word[12]
      |=> osc_mode == ric_pkg::RIC_OSC_RC) else $error("rc mode not decoded");
   chk_wdog_option: assert property ($stable(option_word) |=> watchdog_enable
      == !$past(option_word[`RIC_OPT_WDOG_OFF_BIT])) else $error("watchdog option wrong");
endmodule // ric_ctrl_asserts

bind ric_ctrl ric_ctrl_asserts #(.PC_WIDTH(PC_WIDTH)) u_asserts (.sys_clk, .rst, .option_word,
   .watchdog_expired, .timer_overflow, .global_irq_on_op, .global_irq_off_op,
   .return_from_irq_op, .watchdog_clear_op, .enter_sleep_op, .return_pc, .core_reset,
   .timeout_flag, .powerdown_flag, .interrupt_flag_register, .interrupt_mask_register,
   .global_irq_enable, .vector_load, .vector_addr, .stack_push, .stack_push_data, .sleeping,
   .osc_mode, .watchdog_enable);

// File: dv/ric_ctrl_test.sv
`timescale 1ns/1ns

// ----------------------------------------
// Bench for the reset and interrupt control
// ----------------------------------------
module ric_ctrl_test;
   typedef struct packed {logic [12:0] opt; logic [1:0] osc; logic [3:0] bits;} ric_opt_row_t;
   localparam ric_opt_row_t ROWS [6] = '{'{13'h0000, ric_pkg::RIC_OSC_RC, 4'ha},
      '{13'h1100, ric_pkg::RIC_OSC_HIGH_XTAL, 4'ha}, '{13'h1000, ric_pkg::RIC_OSC_LOW_XTAL, 4'ha},
      '{13'h0e80, ric_pkg::RIC_OSC_RC, 4'h5}, '{13'h1f80, ric_pkg::RIC_OSC_HIGH_XTAL, 4'h5},
      '{13'h1080, ric_pkg::RIC_OSC_UNDEF, 4'hb}};
   logic sys_clk = 0, rst = 1, ext_reset_n_pin = 1, ext_irq_pin = 0, wake_pin_change = 0;
   logic watchdog_expired = 0, timer_overflow = 0, global_irq_on_op = 0, global_irq_off_op = 0;
   logic return_from_irq_op = 0, watchdog_clear_op = 0, enter_sleep_op = 0, soft_irq_op = 0;
   logic sleep_two_select = 0, flag_clear_valid = 0, mask_write_valid = 0;
   logic [1:0] flag_clear_bits = 0, mask_write_data = 0;
   logic [12:0] option_word = 13'h0000;
   logic [11:0] return_pc = 12'h5a3;
   logic core_reset, timeout_flag, powerdown_flag, global_irq_enable, vector_load, stack_push;
   logic sleeping, watchdog_enable, four_clock_cycle, code_protect, osc_high_power;
   logic [1:0] interrupt_flag_register, interrupt_mask_register;
   logic [11:0] vector_addr, stack_push_data;
   ric_pkg::ric_osc_mode_t osc_mode;
   // Option decode bits gathered in the same order as the table rows.
   wire [3:0] opt_bits = {watchdog_enable, four_clock_cycle, code_protect, osc_high_power};
   int errors = 0, num_checks = 0, vec_count = 0, i;

   ric_ctrl #(.PC_WIDTH(12)) uut (.sys_clk, .rst, .option_word, .ext_reset_n_pin, .ext_irq_pin,
      .wake_pin_change, .watchdog_expired, .timer_overflow, .global_irq_on_op,
      .global_irq_off_op, .return_from_irq_op, .watchdog_clear_op, .enter_sleep_op,
      .soft_irq_op, .sleep_two_select, .flag_clear_valid, .flag_clear_bits, .mask_write_valid,
      .mask_write_data, .return_pc, .core_reset, .timeout_flag, .powerdown_flag,
      .interrupt_flag_register, .interrupt_mask_register, .global_irq_enable, .vector_load,
      .vector_addr, .stack_push, .stack_push_data, .sleeping, .osc_mode, .watchdog_enable,
      .four_clock_cycle, .code_protect, .osc_high_power);

   // Clock of 8 ns period.
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   // Counts every vector load so that refused interrupts can be seen.
   always @(posedge sys_clk)
   begin
      if (vector_load === 1'b1)
         vec_count++;
   end

   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tp(input logic t, input logic p);
      check(timeout_flag, t);
      check(powerdown_flag, p);
   endtask

   // Waits for a vector load and checks where it points and what was pushed.
   task take_irq(input logic [11:0] addr);
      for (int k = 0; k < 8 && vector_load !== 1'b1; k++)
         tick(1);
      check(vector_load, 1'h1);
      check(vector_addr, addr);
      check(stack_push, 1'h1);
      check(stack_push_data, return_pc);
      check(global_irq_enable, 1'h0);
      tick(1);
   endtask

   // Low then high on the reset pin, then waits for the reset pulse.
   task ext_reset;
      ext_reset_n_pin = 0;
      tick(3);
      ext_reset_n_pin = 1;
      for (int k = 0; k < 10 && core_reset !== 1'b1; k++)
         tick(1);
      check(core_reset, 1'h1);
      tick(2);
   endtask

   task pulse_sleep(input logic two);
      sleep_two_select = two;
      enter_sleep_op = 1;
      tick(1);
      enter_sleep_op = 0;
      tick(1);
      check(sleeping, 1'h1);
   endtask

   task pulse_wdog(input logic clr);
      watchdog_clear_op = clr;
      watchdog_expired = !clr;
      tick(1);
      watchdog_clear_op = 0;
      watchdog_expired = 0;
      tick(2);
   endtask

   task report_and_stop;
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog on the whole run.
   initial
   begin
      #40000;
      errors++;
      report_and_stop;
   end

   // Main sequence.
   initial
   begin
      tick(20);
      check(core_reset, 1'h1);
      tp(1'h1, 1'h1);
      check({interrupt_flag_register, interrupt_mask_register, global_irq_enable}, 5'h00);
      rst = 0;
      for (i = 0; i < 6; i++)
      begin
         option_word = ROWS[i].opt;
         tick(2);
         check(osc_mode, ROWS[i].osc);
         check(opt_bits, ROWS[i].bits);
      end
      option_word = 13'h0000;
      tick(2);
      pulse_wdog(1);
      tp(1'h1, 1'h1);
      pulse_wdog(0);
      tp(1'h0, 1'h1);
      pulse_sleep(0);
      tp(1'h1, 1'h0);
      pulse_wdog(0);
      tp(1'h0, 1'h0);
      check(sleeping, 1'h0);
      ext_reset;
      tp(1'h0, 1'h0);
      pulse_sleep(0);
      ext_reset;
      tp(1'h1, 1'h0);
      check(sleeping, 1'h0);
      pulse_wdog(1);
      pulse_sleep(1);
      wake_pin_change = 1;
      tick(5);
      tp(1'h1, 1'h0);
      check(sleeping, 1'h0);
      wake_pin_change = 0;
      pulse_sleep(1);
      ext_reset;
      tp(1'h1, 1'h0);
      option_word = 13'h0800;
      tick(2);
      pulse_wdog(0);
      tp(1'h1, 1'h0);
      option_word = 13'h0000;
      mask_write_valid = 1;
      mask_write_data = 2'h1;
      global_irq_on_op = 1;
      tick(1);
      mask_write_valid = 0;
      global_irq_on_op = 0;
      tick(1);
      check(global_irq_enable, 1'h1);
      timer_overflow = 1;
      tick(1);
      timer_overflow = 0;
      take_irq(12'h001);
      flag_clear_valid = 1;
      flag_clear_bits = 2'h1;
      tick(1);
      flag_clear_valid = 0;
      return_from_irq_op = 1;
      tick(1);
      return_from_irq_op = 0;
      tick(1);
      check(global_irq_enable, 1'h1);
      i = vec_count;
      ext_irq_pin = 1;
      tick(6);
      check(interrupt_flag_register, 2'h2);
      check(vec_count, i);
      mask_write_valid = 1;
      mask_write_data = 2'h3;
      tick(1);
      mask_write_valid = 0;
      take_irq(12'h001);
      flag_clear_valid = 1;
      flag_clear_bits = 2'h2;
      tick(1);
      flag_clear_valid = 0;
      timer_overflow = 1;
      tick(1);
      timer_overflow = 0;
      soft_irq_op = 1;
      tick(1);
      soft_irq_op = 0;
      tick(3);
      check(interrupt_flag_register, 2'h1);
      check(vec_count, i + 1);
      flag_clear_valid = 1;
      flag_clear_bits = 2'h1;
      global_irq_on_op = 1;
      tick(1);
      flag_clear_valid = 0;
      global_irq_on_op = 0;
      soft_irq_op = 1;
      tick(1);
      soft_irq_op = 0;
      take_irq(12'h002);
      // The disable instruction drops the enable, and a later flag then raises no vector.
      global_irq_on_op = 1;
      tick(1);
      check(global_irq_enable, 1'h1);
      global_irq_on_op = 0;
      global_irq_off_op = 1;
      tick(1);
      global_irq_off_op = 0;
      check(global_irq_enable, 1'h0);
      i = vec_count;
      timer_overflow = 1;
      tick(1);
      timer_overflow = 0;
      tick(3);
      check(interrupt_flag_register, 2'h1);
      check(vec_count, i);
      report_and_stop;
   end
endmodule // ric_ctrl_test

// File: hw/ric_ctrl.sv
`timescale 1ns/1ns
`include "ric_map.svh"

module ric_ctrl
#(
   parameter int PC_WIDTH = 12
)
(
   input wire logic sys_clk,
   input wire logic rst,
   // Option word, fixed by programming; no instruction path reaches it.
   input wire logic [`RIC_OPT_WIDTH-1:0] option_word,
   // Pins and events.
   input wire logic ext_reset_n_pin,
   input wire logic ext_irq_pin,
   input wire logic wake_pin_change,
   input wire logic watchdog_expired,
   input wire logic timer_overflow,
   // Instruction strobes from the core, one cycle each, and the sleep mode select.
   input wire logic global_irq_on_op,
   input wire logic global_irq_off_op,
   input wire logic return_from_irq_op,
   input wire logic watchdog_clear_op,
   input wire logic enter_sleep_op,
   input wire logic soft_irq_op,
   input wire logic sleep_two_select,
   // Flag and mask register access from the core, and the return address.
   input wire logic flag_clear_valid,
   input wire logic [1:0] flag_clear_bits,
   input wire logic mask_write_valid,
   input wire logic [1:0] mask_write_data,
   input wire logic [PC_WIDTH-1:0] return_pc,
   // Outputs.
   output logic core_reset,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic [1:0] interrupt_flag_register,
   output logic [1:0] interrupt_mask_register,
   output logic global_irq_enable,
   output logic vector_load,
   output logic [PC_WIDTH-1:0] vector_addr,
   output logic stack_push,
   output logic [PC_WIDTH-1:0] stack_push_data,
   output logic sleeping,
   output ric_pkg::ric_osc_mode_t osc_mode,
   output logic watchdog_enable,
   output logic four_clock_cycle,
   output logic code_protect,
   output logic osc_high_power
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic rstn_s1_reg;
   logic rstn_s2_reg;
   logic irq_s1_reg;
   logic irq_s2_reg;
   logic wake_s1_reg;
   logic wake_s2_reg;
   logic rstn_prev_reg;

   // Two flops per pin before any logic looks at it.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rstn_s1_reg <= 1'h1;
         rstn_s2_reg <= 1'h1;
         irq_s1_reg <= 1'h0;
         irq_s2_reg <= 1'h0;
         wake_s1_reg <= 1'h0;
         wake_s2_reg <= 1'h0;
      end
      else
      begin
         rstn_s1_reg <= ext_reset_n_pin;
         rstn_s2_reg <= rstn_s1_reg;
         irq_s1_reg <= ext_irq_pin;
         irq_s2_reg <= irq_s1_reg;
         wake_s1_reg <= wake_pin_change;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   // Previous reset pin level, for the high-low-high pulse detection.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rstn_prev_reg <= 1'h1;
      else
         rstn_prev_reg <= rstn_s2_reg;
   end

   logic ext_reset_done;
   logic wake_edge;
   logic wake_prev_reg;
   logic irq_prev_reg;
   logic ext_irq_event;

   // The pulse counts once the pin returns high.
   assign ext_reset_done = rstn_s2_reg & ~rstn_prev_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wake_prev_reg <= 1'h0;
         irq_prev_reg <= 1'h0;
      end
      else
      begin
         wake_prev_reg <= wake_s2_reg;
         irq_prev_reg <= irq_s2_reg;
      end
   end

   assign wake_edge = wake_s2_reg & ~wake_prev_reg;
   // External request is taken on the pin's rising edge.
   assign ext_irq_event = irq_s2_reg & ~irq_prev_reg;

   // ----------------------------------------
   // Power state
   // ----------------------------------------
   ric_pkg::ric_power_state_t pstate_reg;
   logic wdog_event;

   // Watchdog only resets the core when the option enables it.
   assign wdog_event = watchdog_expired & watchdog_enable;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         pstate_reg <= ric_pkg::RIC_RUN;
      else
      begin
         unique case (pstate_reg)
            ric_pkg::RIC_RUN:
               if (enter_sleep_op)
                  pstate_reg <= sleep_two_select ? ric_pkg::RIC_SLEEP_TWO
                                                 : ric_pkg::RIC_SLEEP_ONE;
            ric_pkg::RIC_SLEEP_ONE:
               if (ext_reset_done || wdog_event)
                  pstate_reg <= ric_pkg::RIC_RUN;
            ric_pkg::RIC_SLEEP_TWO:
               if (ext_reset_done || wdog_event || wake_edge)
                  pstate_reg <= ric_pkg::RIC_RUN;
            default:
               pstate_reg <= ric_pkg::RIC_RUN;
         endcase
      end
   end

   assign sleeping = (pstate_reg != ric_pkg::RIC_RUN);

   // Reset to the core, one cycle, on either run-time reset cause.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         core_reset <= 1'h1;
      else
         core_reset <= ext_reset_done | wdog_event;
   end

   // ----------------------------------------
   // Time-out and power-down flags
   // ----------------------------------------
   logic in_sleep_one;
   assign in_sleep_one = (pstate_reg == ric_pkg::RIC_SLEEP_ONE);

   // Watchdog wins over an external pulse in the same cycle.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         timeout_flag <= `RIC_TIMEOUT_RST;
         powerdown_flag <= `RIC_PWRDN_RST;
      end
      else if (wdog_event)
      begin
         timeout_flag <= 1'h0;
         if (in_sleep_one)
            powerdown_flag <= 1'h0;
      end
      else if (ext_reset_done)
      begin
         if (in_sleep_one)
         begin
            timeout_flag <= 1'h1;
            powerdown_flag <= 1'h0;
         end
      end
      else if (watchdog_clear_op)
      begin
         timeout_flag <= 1'h1;
         powerdown_flag <= 1'h1;
      end
      else if (enter_sleep_op && pstate_reg == ric_pkg::RIC_RUN)
      begin
         timeout_flag <= 1'h1;
         powerdown_flag <= 1'h0;
      end
      // A pin-change wake leaves both flags alone.
   end

   // ----------------------------------------
   // Interrupt flags, mask and global enable
   // ----------------------------------------
   logic [1:0] irq_events;
   assign irq_events[`RIC_IRQ_TIMER_BIT] = timer_overflow;
   assign irq_events[`RIC_IRQ_EXT_BIT] = ext_irq_event;

   // Flags set on events whatever the mask; a set beats a same-cycle clear.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         interrupt_flag_register <= 2'h0;
      else if (core_reset)
         interrupt_flag_register <= 2'h0;
      else if (flag_clear_valid)
         interrupt_flag_register <= (interrupt_flag_register & ~flag_clear_bits)
                                    | irq_events;
      else
         interrupt_flag_register <= interrupt_flag_register | irq_events;
   end

   // Mask register written by the core; cleared on any reset.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         interrupt_mask_register <= 2'h0;
      else if (core_reset)
         interrupt_mask_register <= 2'h0;
      else if (mask_write_valid)
         interrupt_mask_register <= mask_write_data;
   end

   logic take_hw;
   logic take_sw;
   logic irq_request;

   // Global enable follows the instructions; taking an interrupt drops it.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         global_irq_enable <= 1'h0;
      else if (core_reset)
         global_irq_enable <= 1'h0;
      else if (take_hw || take_sw)
         global_irq_enable <= 1'h0;
      else if (global_irq_on_op || return_from_irq_op)
         global_irq_enable <= 1'h1;
      else if (global_irq_off_op)
         global_irq_enable <= 1'h0;
   end

   ric_irq_if irq_bus ();
   assign irq_bus.flag = interrupt_flag_register;
   assign irq_bus.mask = interrupt_mask_register;
   assign irq_bus.global_on = global_irq_enable;
   assign irq_request = irq_bus.request;

   ric_irq_req u_req
   (
      .bus (irq_bus)
   );

   // ----------------------------------------
   // Vector and stack push
   // ----------------------------------------
   assign take_hw = irq_request & ~sleeping & ~core_reset;
   assign take_sw = soft_irq_op & global_irq_enable & ~take_hw & ~core_reset;

   // Return address goes to the stack in the same cycle as the vector.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         vector_load <= 1'h0;
         vector_addr <= '0;
         stack_push <= 1'h0;
         stack_push_data <= '0;
      end
      else
      begin
         vector_load <= take_hw | take_sw;
         stack_push <= take_hw | take_sw;
         if (take_hw || take_sw)
            stack_push_data <= return_pc;
         if (take_hw)
            vector_addr <= PC_WIDTH'(`RIC_VEC_HW_IRQ);
         else if (take_sw)
            vector_addr <= PC_WIDTH'(`RIC_VEC_SW_IRQ);
      end
   end

   // ----------------------------------------
   // Option word decode
   // ----------------------------------------
   logic opt_xtal;
   logic opt_hfreq;
   logic opt_power;

   // Option word arrives only on its own port.
   assign opt_xtal = option_word[`RIC_OPT_OSC_TYPE_BIT];
   assign opt_hfreq = option_word[`RIC_OPT_XFREQ_BIT] & opt_xtal;
   assign opt_power = option_word[`RIC_OPT_POWER_BIT];

   // Decoded settings are registered for clean outputs.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         osc_mode <= ric_pkg::RIC_OSC_RC;
         watchdog_enable <= 1'h0;
         four_clock_cycle <= 1'h0;
         code_protect <= 1'h1;
         osc_high_power <= 1'h0;
      end
      else
      begin
         if (!opt_xtal)
            osc_mode <= ric_pkg::RIC_OSC_RC;
         else if (opt_hfreq)
            osc_mode <= ric_pkg::RIC_OSC_HIGH_XTAL;
         else if (!opt_power)
            osc_mode <= ric_pkg::RIC_OSC_LOW_XTAL;
         else
            osc_mode <= ric_pkg::RIC_OSC_UNDEF;
         watchdog_enable <= ~option_word[`RIC_OPT_WDOG_OFF_BIT];
         four_clock_cycle <= option_word[`RIC_OPT_CYCLE_BIT];
         code_protect <= ~option_word[`RIC_OPT_SECURE_BIT];
         osc_high_power <= opt_power;
      end
   end

endmodule // ric_ctrl

// File: hw/ric_irq_if.sv
`timescale 1ns/1ns
// Carries interrupt flags and masks between the control top and the
// request logic.
interface ric_irq_if;
   logic [1:0] flag;
   logic [1:0] mask;
   logic global_on;
   logic request;
   modport ctrl (output flag, output mask, output global_on, input request);
   modport req (input flag, input mask, input global_on, output request);
endinterface

// File: hw/ric_irq_req.sv
`timescale 1ns/1ns
`include "ric_map.svh"

// ----------------------------------------
// Interrupt request combination
// ----------------------------------------
module ric_irq_req
(
   ric_irq_if.req bus
);
   // Each flag is gated by its own mask and then by the global enable.
   assign bus.request = (|(bus.flag & bus.mask)) & bus.global_on;
endmodule // ric_irq_req

// File: hw/ric_map.svh
`ifndef RIC_MAP_SVH
`define RIC_MAP_SVH

// Option word field positions.
`define RIC_OPT_OSC_TYPE_BIT 12
`define RIC_OPT_WDOG_OFF_BIT 11
`define RIC_OPT_CYCLE_BIT 10
`define RIC_OPT_SECURE_BIT 9
`define RIC_OPT_XFREQ_BIT 8
`define RIC_OPT_POWER_BIT 7
`define RIC_OPT_WIDTH 13

// Interrupt flag and mask bit positions.
`define RIC_IRQ_TIMER_BIT 0
`define RIC_IRQ_EXT_BIT 1

// Program vectors.
`define RIC_VEC_HW_IRQ 12'h001
`define RIC_VEC_SW_IRQ 12'h002

// Reset values of the status flags.
`define RIC_TIMEOUT_RST 1'h1
`define RIC_PWRDN_RST 1'h1

`endif

// File: hw/ric_pkg.sv
package ric_pkg;
   typedef enum logic [1:0] {
      RIC_OSC_RC,
      RIC_OSC_HIGH_XTAL,
      RIC_OSC_LOW_XTAL,
      RIC_OSC_UNDEF
   } ric_osc_mode_t;

   typedef enum logic [1:0] {
      RIC_RUN,
      RIC_SLEEP_ONE,
      RIC_SLEEP_TWO
   } ric_power_state_t;
endpackage
